// >>> dac_level_ctrl.sv
`timescale 1ns/100ps
// Operation
// - Soft ramp moves level 1/8 dB per frame, 1 dB per 8 frames.
// - Zero-cross mode applies a level change only at a zero crossing.
// - Without a crossing the pending change applies after 512 samples.
// - Crossing detection and level updates run separately per channel.
// - Ramp plus zero-cross takes each 1/8 dB step at a crossing.
// - Change-mode field: 00 now, 01 zero, 10 ramp, 11 step-on-crossing.
// - Mixing field routes left, right, mix or silence to each output.
// - Level link makes both outputs use the channel A level byte.
// - Level byte: mute bit 7, seven-bit attenuation in 1 dB steps.
// - Codes above 119 dB act exactly like the mute bit.
// - Mute silences the channel through the same change mechanism.
// - A muted channel drives its silence flag output active.
// - Flag link ANDs both channel conditions onto both flags.
// - Polarity bits invert the sign of their channel.
// - Host port enable resets to 0; setting it hands control over.
// - Low-power bit resets set and holds low power; registers kept.
// - Freeze stores writes; clearing freeze applies them together.
// - Divide bit halves the internal processing clock.
// - Reset pin low: low power, defaults, control port refused.
// - Stand-alone: reset pin low gives low power, high runs.
// - Left-then-right pairs output together; right-then-left lag one.
module dac_level_ctrl (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic cs_n,
    input wire logic cclk,
    input wire logic cdin,
    input wire logic bit_clk,
    input wire logic frame_select_clk,
    input wire logic audio_serial_in,
    output dac_level_pkg::sample_pair_t out_pair,
    output logic out_valid,
    output logic chan_a_silence_flag_out,
    output logic chan_b_silence_flag_out,
    output logic low_power_out
);
    logic [6:0] pin_raw;
    logic [6:0] s1_reg;
    logic [6:0] s2_reg;
    logic [6:0] s3_reg;
    logic [6:0] pin_f_reg;
    logic [6:0] pin_d_reg;
    logic int_rst;
    logic cs_fall;
    logic cclk_rise;
    logic bclk_rise;
    logic lr_edge;
    logic byte_done;
    logic wr_go;
    logic [7:0] byte_in;
    dac_level_pkg::spi_state_t spi_state_reg;
    logic [7:0] spi_shift_reg;
    logic [2:0] spi_cnt_reg;
    logic [6:0] map_reg;
    logic map_inc_reg;
    dac_level_pkg::ctrl_regs_t shadow_reg;
    dac_level_pkg::ctrl_regs_t eff_reg;
    dac_level_pkg::ctrl_regs_t cfg;
    dac_level_pkg::change_mode_t mode;
    logic low_power;
    logic [23:0] rx_shift_reg;
    logic [4:0] rx_cnt_reg;
    logic [23:0] left_hold_reg;
    logic [23:0] left_reg;
    logic [23:0] right_reg;
    logic pair_tick_reg;
    logic pend_reg;
    logic phase_reg;
    logic core_go;
    logic signed [23:0] mix_src [2];
    logic signed [23:0] scaled [2];
    logic [1:0] muted;
    logic [1:0] inv;

    // Three-stage synchronisers; a level counts once stages two and three agree
    assign pin_raw = {reset_pin_n, cs_n, cclk, cdin, bit_clk,
        frame_select_clk, audio_serial_in};
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_reg <= dac_level_pkg::PIN_IDLE;
            s2_reg <= dac_level_pkg::PIN_IDLE;
            s3_reg <= dac_level_pkg::PIN_IDLE;
            pin_f_reg <= dac_level_pkg::PIN_IDLE;
            pin_d_reg <= dac_level_pkg::PIN_IDLE;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_f_reg <= (s2_reg & s3_reg) | (pin_f_reg & (s2_reg ^ s3_reg));
            pin_d_reg <= pin_f_reg;
        end
    end

    // Reset pin low holds everything at defaults
    assign int_rst = rst | ~pin_f_reg[dac_level_pkg::PIN_RST];
    assign cs_fall = pin_d_reg[dac_level_pkg::PIN_CS]
        & ~pin_f_reg[dac_level_pkg::PIN_CS];
    assign cclk_rise = ~pin_d_reg[dac_level_pkg::PIN_CCLK]
        & pin_f_reg[dac_level_pkg::PIN_CCLK];
    assign bclk_rise = ~pin_d_reg[dac_level_pkg::PIN_BCLK]
        & pin_f_reg[dac_level_pkg::PIN_BCLK];
    assign lr_edge = pin_d_reg[dac_level_pkg::PIN_LR]
        ^ pin_f_reg[dac_level_pkg::PIN_LR];
    assign byte_in = {spi_shift_reg[6:0], pin_f_reg[dac_level_pkg::PIN_CDIN]};
    assign byte_done = ~pin_f_reg[dac_level_pkg::PIN_CS] & cclk_rise
        & (spi_cnt_reg == 3'h7);
    assign wr_go = byte_done && (spi_state_reg == dac_level_pkg::SP_DATA);

    // Control port: chip address byte, map byte, then data bytes
    always_ff @(posedge mclk) begin
        if (int_rst) begin
            spi_state_reg <= dac_level_pkg::SP_IGNORE;
            spi_shift_reg <= 8'h00;
            spi_cnt_reg <= 3'h0;
            map_reg <= 7'h00;
            map_inc_reg <= 1'b0;
        end else if (cs_fall) begin
            spi_state_reg <= dac_level_pkg::SP_ADDR;
            spi_cnt_reg <= 3'h0;
        end else if (~pin_f_reg[dac_level_pkg::PIN_CS] && cclk_rise) begin
            spi_shift_reg <= byte_in;
            spi_cnt_reg <= spi_cnt_reg + 3'h1;
            if (spi_cnt_reg == 3'h7) begin
                case (spi_state_reg)
                    dac_level_pkg::SP_ADDR: begin
                        if (byte_in[7:1] == dac_level_pkg::CHIP_ADDR
                                && !byte_in[0]) begin
                            spi_state_reg <= dac_level_pkg::SP_MAP;
                        end else begin
                            spi_state_reg <= dac_level_pkg::SP_IGNORE;
                        end
                    end
                    dac_level_pkg::SP_MAP: begin
                        map_reg <= byte_in[6:0];
                        map_inc_reg <= byte_in[7];
                        spi_state_reg <= dac_level_pkg::SP_DATA;
                    end
                    dac_level_pkg::SP_DATA: begin
                        if (map_inc_reg) begin
                            map_reg <= map_reg + 7'h01;
                        end
                    end
                    default: begin
                        spi_state_reg <= dac_level_pkg::SP_IGNORE;
                    end
                endcase
            end
        end
    end

    // Written register copies; kept through low power
    always_ff @(posedge mclk) begin
        if (int_rst) begin
            shadow_reg <= dac_level_pkg::REGS_RST;
        end else if (wr_go) begin
            case (map_reg)
                dac_level_pkg::MODE1_OFS: shadow_reg.mode1 <= byte_in;
                dac_level_pkg::MIX_OFS: shadow_reg.mix <= byte_in;
                dac_level_pkg::CHA_OFS: shadow_reg.cha <= byte_in;
                dac_level_pkg::CHB_OFS: shadow_reg.chb <= byte_in;
                dac_level_pkg::MODE2_OFS: shadow_reg.mode2 <= byte_in;
                default: shadow_reg <= shadow_reg;
            endcase
        end
    end

    // Working copy follows the written one unless frozen
    always_ff @(posedge mclk) begin
        if (int_rst) begin
            eff_reg <= dac_level_pkg::REGS_RST;
        end else if (!shadow_reg.mode2[dac_level_pkg::FREEZE_BIT]) begin
            eff_reg <= shadow_reg;
        end
    end

    // Stand-alone mode runs on default settings
    assign cfg = eff_reg.mode2[dac_level_pkg::HOST_EN_BIT] ? eff_reg
        : dac_level_pkg::REGS_RST;
    assign low_power = int_rst
        | (eff_reg.mode2[dac_level_pkg::HOST_EN_BIT]
        & eff_reg.mode2[dac_level_pkg::LOW_POWER_BIT]);
    assign mode = dac_level_pkg::change_mode_t'(
        cfg.mix[dac_level_pkg::MIX_MODE_HI:dac_level_pkg::MIX_MODE_LO]);
    assign inv = {cfg.mode2[dac_level_pkg::INV_B_BIT],
        cfg.mode2[dac_level_pkg::INV_A_BIT]};

    // Serial audio receiver, left justified, frame clock high is left
    always_ff @(posedge mclk) begin
        if (int_rst) begin
            rx_shift_reg <= 24'h00_0000;
            rx_cnt_reg <= 5'h00;
            left_hold_reg <= 24'h00_0000;
            left_reg <= 24'h00_0000;
            right_reg <= 24'h00_0000;
            pair_tick_reg <= 1'b0;
        end else begin
            pair_tick_reg <= 1'b0;
            if (lr_edge) begin
                rx_cnt_reg <= 5'h00;
                if (!pin_f_reg[dac_level_pkg::PIN_LR]) begin
                    left_hold_reg <= rx_shift_reg;
                end else begin
                    // Right word ends: release the pair together
                    left_reg <= left_hold_reg;
                    right_reg <= rx_shift_reg;
                    pair_tick_reg <= 1'b1;
                end
            end else if (bclk_rise && rx_cnt_reg < dac_level_pkg::SAMPLE_BITS) begin
                rx_shift_reg <= {rx_shift_reg[22:0],
                    pin_f_reg[dac_level_pkg::PIN_DATA]};
                rx_cnt_reg <= rx_cnt_reg + 5'h01;
            end
        end
    end

    // Internal processing rate, halved when the divide bit is set
    assign core_go = pend_reg
        & (~cfg.mode2[dac_level_pkg::DIV_BIT] | phase_reg);
    always_ff @(posedge mclk) begin
        if (int_rst) begin
            pend_reg <= 1'b0;
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
            if (pair_tick_reg) begin
                pend_reg <= 1'b1;
            end else if (core_go) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // Channel mixing
    function automatic logic signed [23:0] pick(input logic [1:0] sel,
            input logic signed [23:0] l, input logic signed [23:0] r);
        logic signed [24:0] sum;
        sum = 25'(l) + 25'(r);
        case (sel)
            2'h1: pick = r;
            2'h2: pick = l;
            2'h3: pick = 24'(sum >>> 1);
            default: pick = 24'h00_0000;
        endcase
    endfunction
    assign mix_src[0] = pick(cfg.mix[dac_level_pkg::MIX_A_HI:dac_level_pkg::MIX_A_LO],
        left_reg, right_reg);
    assign mix_src[1] = pick(cfg.mix[dac_level_pkg::MIX_B_HI:dac_level_pkg::MIX_B_LO],
        left_reg, right_reg);

    // Per-channel level tracking
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic [7:0] vol_byte;
        logic [9:0] target;
        logic [9:0] cur_reg;
        logic [9:0] tmo_reg;
        logic [23:0] prev_reg;
        logic zc;
        logic go;
        logic [9:0] step_lvl;

        assign vol_byte = (ch == 0 || cfg.mix[dac_level_pkg::MIX_LINK_BIT])
            ? cfg.cha : cfg.chb;
        assign muted[ch] = vol_byte[dac_level_pkg::MUTE_BIT]
            | (vol_byte[dac_level_pkg::LEVEL_MSB:dac_level_pkg::LEVEL_LSB]
            > dac_level_pkg::MAX_ATTEN_DB);
        assign target = muted[ch] ? dac_level_pkg::MUTE_LEVEL
            : {vol_byte[dac_level_pkg::LEVEL_MSB:dac_level_pkg::LEVEL_LSB],
            3'h0};
        assign zc = (mix_src[ch] == 24'h00_0000)
            | (mix_src[ch][23] != prev_reg[23]);
        assign go = zc | (tmo_reg >= dac_level_pkg::ZC_TIMEOUT - 10'h001);
        assign step_lvl = (cur_reg < target) ? cur_reg + 10'h001
            : cur_reg - 10'h001;

        // Level moves once per processed sample pair
        always_ff @(posedge mclk) begin
            if (int_rst) begin
                cur_reg <= dac_level_pkg::MUTE_LEVEL;
                tmo_reg <= 10'h000;
                prev_reg <= 24'h00_0000;
            end else if (core_go) begin
                prev_reg <= mix_src[ch];
                if (cur_reg == target) begin
                    tmo_reg <= 10'h000;
                end else begin
                    case (mode)
                        dac_level_pkg::CHG_NOW: cur_reg <= target;
                        dac_level_pkg::CHG_SOFT: cur_reg <= step_lvl;
                        dac_level_pkg::CHG_ZERO: begin
                            if (go) begin
                                cur_reg <= target;
                            end
                        end
                        default: begin
                            if (go) begin
                                cur_reg <= step_lvl;
                            end
                        end
                    endcase
                    tmo_reg <= go ? 10'h000 : tmo_reg + 10'h001;
                end
            end
        end

        level_scaler u_scaler (
            .sample_in(mix_src[ch]),
            .level_in(cur_reg),
            .sample_out(scaled[ch])
        );
    end

    // Polarity inversion with saturation of the most negative code
    function automatic logic [23:0] flip(input logic en,
            input logic signed [23:0] v);
        if (!en) begin
            flip = v;
        end else if (v == 24'h80_0000) begin
            flip = 24'h7F_FFFF;
        end else begin
            flip = -v;
        end
    endfunction

    // Output samples; the low-power bit only stops the strobe, the pair holds
    always_ff @(posedge mclk) begin
        if (int_rst) begin
            out_pair <= '0;
            out_valid <= 1'b0;
        end else if (low_power) begin
            out_valid <= 1'b0;
        end else begin
            out_valid <= core_go;
            if (core_go) begin
                out_pair.chan_a <= flip(inv[0], scaled[0]);
                out_pair.chan_b <= flip(inv[1], scaled[1]);
            end
        end
    end

    // Silence flags, optionally linked, also active in low power
    always_ff @(posedge mclk) begin
        if (low_power) begin
            chan_a_silence_flag_out <= 1'b1;
            chan_b_silence_flag_out <= 1'b1;
            low_power_out <= 1'b1;
        end else begin
            low_power_out <= 1'b0;
            if (cfg.mode2[dac_level_pkg::FLAG_LINK_BIT]) begin
                chan_a_silence_flag_out <= &muted;
                chan_b_silence_flag_out <= &muted;
            end else begin
                chan_a_silence_flag_out <= muted[0];
                chan_b_silence_flag_out <= muted[1];
            end
        end
    end
endmodule

// >>> dac_level_pkg.sv
package dac_level_pkg;

    // Register offsets on the control port
    localparam logic [6:0] MODE1_OFS = 7'h01;
    localparam logic [6:0] MIX_OFS = 7'h02;
    localparam logic [6:0] CHA_OFS = 7'h03;
    localparam logic [6:0] CHB_OFS = 7'h04;
    localparam logic [6:0] MODE2_OFS = 7'h05;

    // Reset values
    localparam logic [7:0] MODE1_RST = 8'h80;
    localparam logic [7:0] MIX_RST = 8'h49;
    localparam logic [7:0] CHA_RST = 8'h00;
    localparam logic [7:0] CHB_RST = 8'h00;
    localparam logic [7:0] MODE2_RST = 8'h10;

    // Level and mixing field positions
    localparam int MIX_LINK_BIT = 7;
    localparam int MIX_MODE_HI = 6;
    localparam int MIX_MODE_LO = 5;
    localparam int MIX_A_HI = 3;
    localparam int MIX_A_LO = 2;
    localparam int MIX_B_HI = 1;
    localparam int MIX_B_LO = 0;

    // Channel level field positions
    localparam int MUTE_BIT = 7;
    localparam int LEVEL_MSB = 6;
    localparam int LEVEL_LSB = 0;

    // Second mode register field positions
    localparam int INV_A_BIT = 7;
    localparam int INV_B_BIT = 6;
    localparam int HOST_EN_BIT = 5;
    localparam int LOW_POWER_BIT = 4;
    localparam int FLAG_LINK_BIT = 3;
    localparam int FREEZE_BIT = 2;
    localparam int DIV_BIT = 1;

    // Level arithmetic; MUTE_LEVEL in eighths of a dB, MAX_ATTEN_DB and DB_PER_SHIFT in whole dB
    localparam logic [6:0] MAX_ATTEN_DB = 7'h77;
    localparam logic [9:0] MUTE_LEVEL = 10'h3C0;
    localparam logic [6:0] DB_PER_SHIFT = 7'h06;
    localparam logic [15:0] EIGHTH_DB_LOSS = 16'h01D4;
    localparam logic [5:0][15:0] GAIN_TABLE = {16'h47FB, 16'h50C3,
        16'h5A9E, 16'h65AD, 16'h7215, 16'h8000};

    // Zero-cross timeout, in sample periods
    localparam logic [9:0] ZC_TIMEOUT = 10'h200;

    // Serial audio word width
    localparam int SAMPLE_W = 24;
    localparam logic [4:0] SAMPLE_BITS = 5'h18;

    // Chip address on the control port, value arbitrary
    localparam logic [6:0] CHIP_ADDR = 7'h4C;

    // Synchronised pin vector layout
    localparam int PIN_RST = 6;
    localparam int PIN_CS = 5;
    localparam int PIN_CCLK = 4;
    localparam int PIN_CDIN = 3;
    localparam int PIN_BCLK = 2;
    localparam int PIN_LR = 1;
    localparam int PIN_DATA = 0;
    localparam logic [6:0] PIN_IDLE = 7'h20;

    typedef enum logic [1:0] {
        CHG_NOW,
        CHG_ZERO,
        CHG_SOFT,
        CHG_SOFT_ZERO
    } change_mode_t;

    typedef enum logic [1:0] {
        SP_ADDR,
        SP_MAP,
        SP_DATA,
        SP_IGNORE
    } spi_state_t;

    typedef struct packed {
        logic [7:0] mode1;
        logic [7:0] mix;
        logic [7:0] cha;
        logic [7:0] chb;
        logic [7:0] mode2;
    } ctrl_regs_t;

    localparam ctrl_regs_t REGS_RST = '{MODE1_RST, MIX_RST, CHA_RST,
        CHB_RST, MODE2_RST};

    typedef struct packed {
        logic [SAMPLE_W-1:0] chan_a;
        logic [SAMPLE_W-1:0] chan_b;
    } sample_pair_t;

endpackage

// >>> level_scaler.sv
`timescale 1ns/100ps
module level_scaler (
    input wire logic signed [23:0] sample_in,
    input wire logic [9:0] level_in,
    output logic signed [23:0] sample_out
);
    logic [6:0] db;
    logic [2:0] frac;
    logic [6:0] shift;
    logic [2:0] rem;
    logic [15:0] mant;
    logic [15:0] ffac;
    logic signed [40:0] p1;
    logic signed [40:0] p2;
    logic signed [23:0] s1;
    logic signed [23:0] s2;

    // Whole 6 dB steps shift, leftover whole dB scale by a small gain table, eighths by a linear factor
    always_comb begin
        db = level_in[9:3];
        frac = level_in[2:0];
        shift = db / dac_level_pkg::DB_PER_SHIFT;
        rem = 3'(db - 7'(shift * dac_level_pkg::DB_PER_SHIFT));
        mant = dac_level_pkg::GAIN_TABLE[rem];
        ffac = 16'(16'h8000 - 16'(16'(frac) * dac_level_pkg::EIGHTH_DB_LOSS));
        p1 = 41'(sample_in) * 41'(signed'({1'b0, mant}));
        s1 = 24'(p1 >>> 15);
        p2 = 41'(s1) * 41'(signed'({1'b0, ffac}));
        s2 = 24'(p2 >>> 15);
        if (level_in >= dac_level_pkg::MUTE_LEVEL) begin
            sample_out = 24'h00_0000;
        end else begin
            sample_out = s2 >>> shift;
        end
    end
endmodule

// >>> audio_host_model.sv
`timescale 1ns/100ps
module audio_host_model (
    input wire logic mclk,
    output logic cs_n,
    output logic cclk,
    output logic cdin,
    output logic bit_clk,
    output logic frame_select_clk,
    output logic audio_serial_in
);
    // Idle levels at time zero
    initial begin
        cs_n = 1'b1;
        cclk = 1'b1;
        cdin = 1'b0;
        bit_clk = 1'b0;
        frame_select_clk = 1'b0;
        audio_serial_in = 1'b0;
    end
    // Every pin level stands three master clocks so the sync agrees
    task automatic hold();
        repeat (3) @(negedge mclk);
    endtask
    // One control byte, MSB first, taken on cclk rising
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            cclk = 1'b0;
            cdin = b[i];
            hold();
            cclk = 1'b1;
            hold();
        end
    endtask
    // Chip address, map byte, data byte in one select window
    task automatic write_reg(input logic [6:0] map, input logic [7:0] d);
        cs_n = 1'b0;
        hold();
        put_byte({dac_level_pkg::CHIP_ADDR, 1'b0});
        put_byte({1'b0, map});
        put_byte(d);
        hold();
        cs_n = 1'b1;
        cdin = ~cdin; // Released line does not keep the last bit
        repeat (6) hold();
    endtask
    // One word, two's complement MSB first on bit clock rising
    task automatic put_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            bit_clk = 1'b0;
            audio_serial_in = w[i];
            hold();
            bit_clk = 1'b1;
            hold();
        end
        audio_serial_in = ~audio_serial_in;
    endtask
    // Left word with frame clock high, then right word low
    task automatic send_frame(input logic [23:0] l, input logic [23:0] r);
        frame_select_clk = 1'b1;
        hold();
        put_word(l);
        frame_select_clk = 1'b0;
        hold();
        put_word(r);
        frame_select_clk = 1'b1;
        hold();
    endtask
endmodule

// >>> dac_level_ctrl_asserts.sv
`timescale 1ns/100ps
module dac_level_ctrl_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic frame_select_clk,
    input wire dac_level_pkg::sample_pair_t out_pair,
    input wire logic out_valid,
    input wire logic chan_a_silence_flag_out,
    input wire logic chan_b_silence_flag_out,
    input wire logic low_power_out
);
    logic fsel_q;
    logic [7:0] since_rise;
    // Cycles since the frame clock last rose, saturating
    always_ff @(posedge mclk) begin
        fsel_q <= frame_select_clk;
        if (rst) begin
            since_rise <= 8'hFF;
        end else if (frame_select_clk && !fsel_q) begin
            since_rise <= 8'h00;
        end else if (since_rise != 8'hFF) begin
            since_rise <= since_rise + 8'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    a_reset_quiet: assert property (
        rst |=> !out_valid && out_pair == '0)
        else $error("output active during reset");
    a_reset_flags: assert property (
        rst |=> low_power_out && chan_a_silence_flag_out
            && chan_b_silence_flag_out)
        else $error("reset state outputs wrong");
    a_pin_low_power: assert property (disable iff (rst)
        !reset_pin_n [*6] |-> low_power_out && !out_valid
            && chan_a_silence_flag_out && chan_b_silence_flag_out)
        else $error("reset pin low but device active");
    a_pin_release: assert property (disable iff (rst)
        !reset_pin_n [*6] ##1 reset_pin_n |-> low_power_out [*2])
        else $error("device left reset too soon");
    a_valid_pulse: assert property (disable iff (rst)
        out_valid |=> !out_valid)
        else $error("pair strobe longer than one cycle");
    a_pair_holds: assert property (disable iff (rst || !reset_pin_n)
        !out_valid |-> $stable(out_pair))
        else $error("pair changed without strobe");
    a_power_quiet: assert property (disable iff (rst)
        low_power_out && $past(low_power_out) |-> !out_valid
            && chan_a_silence_flag_out && chan_b_silence_flag_out)
        else $error("output produced in low power");
    a_pair_timing: assert property (disable iff (rst)
        out_valid |-> since_rise >= 8'h03 && since_rise <= 8'h0C)
        else $error("pair not released at end of right word");
endmodule
bind dac_level_ctrl dac_level_ctrl_asserts chk (.mclk(mclk), .rst(rst),
    .reset_pin_n(reset_pin_n), .frame_select_clk(frame_select_clk),
    .out_pair(out_pair), .out_valid(out_valid),
    .chan_a_silence_flag_out(chan_a_silence_flag_out),
    .chan_b_silence_flag_out(chan_b_silence_flag_out),
    .low_power_out(low_power_out));

// >>> dac_level_ctrl_test.sv
`timescale 1ns/100ps
module dac_level_ctrl_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b0;
    logic cs_n, cclk, cdin, bit_clk, frame_select_clk, audio_serial_in;
    logic out_valid, chan_a_silence_flag_out, chan_b_silence_flag_out;
    logic low_power_out;
    dac_level_pkg::sample_pair_t out_pair, got;
    int failures = 0;
    int tests_run = 0;
    int n_valid = 0;
    localparam logic [23:0] lw = 24'h12_3456;
    localparam logic [23:0] rw = 24'h65_4321;
    // Master clock, far above the frame rate
    always #5 mclk = ~mclk;
    // Capture each released pair
    always @(posedge mclk) begin
        if (out_valid === 1'b1) begin
            got <= out_pair;
            n_valid <= n_valid + 1;
        end
    end
    audio_host_model src (.mclk(mclk), .cs_n(cs_n), .cclk(cclk),
        .cdin(cdin), .bit_clk(bit_clk),
        .frame_select_clk(frame_select_clk),
        .audio_serial_in(audio_serial_in));
    dac_level_ctrl DUT (.mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n),
        .cs_n(cs_n), .cclk(cclk), .cdin(cdin), .bit_clk(bit_clk),
        .frame_select_clk(frame_select_clk),
        .audio_serial_in(audio_serial_in), .out_pair(out_pair),
        .out_valid(out_valid),
        .chan_a_silence_flag_out(chan_a_silence_flag_out),
        .chan_b_silence_flag_out(chan_b_silence_flag_out),
        .low_power_out(low_power_out));
    // Shared comparison
    task automatic check(input string what, input logic [23:0] e,
        input logic [23:0] s);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic flags(input logic ea, input logic eb);
        check("flag_a", 24'(ea), 24'(chan_a_silence_flag_out));
        check("flag_b", 24'(eb), 24'(chan_b_silence_flag_out));
    endtask
    task automatic lp(input logic e);
        check("low_power", 24'(e), 24'(low_power_out));
    endtask
    task automatic wr(input logic [6:0] map, input logic [7:0] d);
        src.write_reg(map, d);
    endtask
    // Two frames, counting the pairs released
    task automatic frame(input int n);
        int start;
        start = n_valid;
        repeat (2) begin
            src.send_frame(lw, rw);
            repeat (20) @(negedge mclk);
        end
        check("pairs", 24'(n), 24'(n_valid - start));
    endtask
    task automatic pair(input logic [23:0] a, input logic [23:0] b);
        frame(2);
        check("chan_a", a, got.chan_a);
        check("chan_b", b, got.chan_b);
    endtask
    task automatic t_reset();
        lp(1'b0);
        reset_pin_n = 1'b0;
        repeat (10) @(negedge mclk);
        lp(1'b1);
        flags(1'b1, 1'b1);
        reset_pin_n = 1'b1;
        repeat (10) @(negedge mclk);
        lp(1'b0);
        $display("test reset done");
    endtask
    task automatic t_enable();
        wr(7'h05, 8'h30);
        lp(1'b1);
        frame(0);
        wr(7'h05, 8'h20);
        lp(1'b0);
        $display("test enable done");
    endtask
    task automatic t_mix();
        wr(7'h02, 8'h09);
        pair(lw, rw);
        wr(7'h02, 8'h06);
        pair(rw, lw);
        wr(7'h02, 8'h0C);
        pair(24'h3B_BBBB, 24'h00_0000);
        wr(7'h02, 8'h09);
        $display("test mix done");
    endtask
    task automatic t_invert();
        wr(7'h05, 8'hA0);
        pair(-lw, rw);
        wr(7'h05, 8'h60);
        pair(lw, -rw);
        wr(7'h05, 8'h20);
        $display("test invert done");
    endtask
    task automatic t_mute();
        wr(7'h03, 8'h80);
        pair(24'h00_0000, rw);
        flags(1'b1, 1'b0);
        wr(7'h05, 8'h28);
        flags(1'b0, 1'b0);
        wr(7'h04, 8'h80);
        frame(2);
        flags(1'b1, 1'b1);
        wr(7'h05, 8'h20);
        wr(7'h04, 8'h00);
        wr(7'h03, 8'h78);
        pair(24'h00_0000, rw);
        flags(1'b1, 1'b0);
        wr(7'h03, 8'h77);
        frame(2);
        flags(1'b0, 1'b0);
        wr(7'h03, 8'h00);
        $display("test mute done");
    endtask
    task automatic t_freeze();
        wr(7'h05, 8'h24);
        wr(7'h03, 8'h80);
        pair(lw, rw);
        flags(1'b0, 1'b0);
        wr(7'h05, 8'h20);
        pair(24'h00_0000, rw);
        flags(1'b1, 1'b0);
        $display("test freeze done");
    endtask
    task automatic t_link();
        wr(7'h02, 8'h89);
        pair(24'h00_0000, 24'h00_0000);
        flags(1'b1, 1'b1);
        wr(7'h02, 8'h09);
        wr(7'h03, 8'h00);
        pair(lw, rw);
        wr(7'h05, 8'h22);
        pair(lw, rw);
        wr(7'h02, 8'h29);
        wr(7'h03, 8'h80);
        pair(lw, rw);
        $display("test link done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        reset_pin_n = 1'b1;
        repeat (10) @(negedge mclk);
        t_reset();
        t_enable();
        t_mix();
        t_invert();
        t_mute();
        t_freeze();
        t_link();
        conclude();
    end
    // Watchdog, several times the expected run
    initial begin
        #500us;
        failures++;
        conclude();
    end
endmodule
